// ==== hdl/bcq_pkg.sv ====
package bcq_pkg;

    // ************************************************************
    // Register map, 8-bit registers on a 4-bit address
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_MODE = 4'h1;
    localparam logic [3:0] OFF_A_EXT = 4'h2;
    localparam logic [3:0] OFF_A_HIGH = 4'h3;
    localparam logic [3:0] OFF_A_LOW = 4'h4;
    localparam logic [3:0] OFF_B_EXT = 4'h5;
    localparam logic [3:0] OFF_B_HIGH = 4'h6;
    localparam logic [3:0] OFF_B_LOW = 4'h7;
    localparam logic [3:0] OFF_STATUS = 4'h8;

    // ************************************************************
    // Control, mode and status register fields, reset values and mask codes
    // ************************************************************
    localparam int CTRL_AMASK_HI = 7;
    localparam int CTRL_AMASK_LO = 6;
    localparam int CTRL_BMASK_HI = 5;
    localparam int CTRL_BMASK_LO = 4;
    localparam int CTRL_A_DIR_EN = 3;
    localparam int CTRL_A_DIR_VAL = 2;
    localparam int CTRL_B_DIR_EN = 1;
    localparam int CTRL_B_DIR_VAL = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int MODE_AB_BKPT_EN = 7;
    localparam int MODE_FULL = 6;
    localparam logic [7:0] MODE_RESET = 8'h00;

    localparam int EXT_W = 6;
    localparam logic [5:0] EXT_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    localparam int STAT_A_STICKY = 0;
    localparam int STAT_B_STICKY = 1;
    localparam int STAT_A_LIVE = 2;
    localparam int STAT_B_LIVE = 3;

    localparam logic [1:0] MASK_NONE = 2'h0;
    localparam logic [1:0] MASK_PAGE_ONLY = 2'h3;

endpackage : bcq_pkg

// ==== hdl/bcq_comparator.sv ====
`timescale 1ns/1ps
`default_nettype none

module bcq_comparator (
    input wire logic [5:0] refExt,       // Extended compare bits
    input wire logic [7:0] refHigh,      // High compare byte
    input wire logic [7:0] refLow,       // Low compare byte
    input wire logic [1:0] maskPair,     // Effective mask pair, high:low
    input wire logic dataMode,           // Compare data bus, not address
    input wire logic pageSel,            // Program page is being accessed
    input wire logic [15:0] cpuAddr,     // CPU address
    input wire logic [5:0] pageIndex,    // Program page index
    input wire logic [15:0] cpuData,     // CPU data
    input wire logic dirEnable,          // Direction qualifies match
    input wire logic dirValue,           // 1 read, 0 write
    input wire logic cpuRead,            // 1 read cycle, 0 write cycle
    output logic match                   // Combinational match
);

    logic ignoreLow;
    logic ignoreHigh;
    logic extOk;
    logic highOk;
    logic lowOk;
    logic dirOk;
    logic addrOk;
    logic dataOk;

    always_comb begin
        // 1:0 falls back to full compare, 0:1 drops low, 1:1 drops both
        ignoreLow = maskPair[0];
        ignoreHigh = maskPair[1] & maskPair[0];
        extOk = !pageSel || (refExt == pageIndex);
        if (ignoreHigh) begin
            highOk = 1'b1;
        end else if (pageSel) begin
            highOk = (refHigh[5:0] == cpuAddr[13:8]);
        end else begin
            highOk = (refHigh == cpuAddr[15:8]);
        end
        lowOk = ignoreLow || (refLow == cpuAddr[7:0]);
        // Page-only window makes sense only on a paged access
        addrOk = extOk && highOk && lowOk && !(ignoreHigh && !pageSel);
        // Data bytes: 0:0 both, 0:1 high, 1:0 low, 1:1 none; no page
        dataOk = (maskPair[1] || (refHigh == cpuData[15:8]))
            && (maskPair[0] || (refLow == cpuData[7:0]));
        dirOk = !dirEnable || (dirValue == cpuRead);
        match = (dataMode ? dataOk : addrOk) && dirOk;
    end

endmodule : bcq_comparator

`default_nettype wire

// ==== hdl/bcq_qualifier.sv ====
// Contract
// - Control bits 7:6, 5:4, 3:0; reset zero
// - Capture mode forces first mask to zero
// - Capture mode: second mask only in full
// - First mask can drop high/low bytes
// - Paged full compare uses twenty bits
// - Unpaged full compare uses sixteen bits
// - Mask 1:0 acts as full compare
// - Mask 1:1 matches page, paged access only
// - Full mode: second mask selects data bytes
// - A direction enable gates direction check
// - A direction value: 0 write, 1 read
// - B direction enable gates direction check
// - B direction value: 0 write, 1 read
// - Full mode ignores B direction bits
// - Breakpoint enable and full-mode select controls
// - Mask 0:1 drops low, 1:1 both
// - Data masks: both, high, low, none
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module bcq_qualifier (
    input wire logic sys_clk,            // System bus clock, 125 MHz
    input wire logic rst,                // Asynchronous reset, active high
    input wire logic [3:0] regAddr,      // Register address
    input wire logic [7:0] regWrData,    // Register write data
    input wire logic regWrite,           // Register write strobe
    input wire logic regRead,            // Register read strobe
    output logic [7:0] regRdData,        // Read data, cycle after strobe
    input wire logic busValid,           // CPU bus cycle valid
    input wire logic [15:0] cpuAddr,     // CPU address
    input wire logic [15:0] cpuData,     // CPU data
    input wire logic cpuRead,            // 1 read cycle, 0 write cycle
    input wire logic pageAccess,         // Access falls in program page window
    input wire logic [5:0] programPageIndex, // Current program page
    output logic matchA,                 // Comparator A match pulse
    output logic matchB                  // Comparator B match pulse
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [5:0] aExt_reg;
    logic [5:0] aExt_next;
    logic [7:0] aHigh_reg;
    logic [7:0] aHigh_next;
    logic [7:0] aLow_reg;
    logic [7:0] aLow_next;
    logic [5:0] bExt_reg;
    logic [5:0] bExt_next;
    logic [7:0] bHigh_reg;
    logic [7:0] bHigh_next;
    logic [7:0] bLow_reg;
    logic [7:0] bLow_next;
    logic [1:0] sticky_reg;
    logic [1:0] sticky_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    logic bkptMode;
    logic fullMode;

    always_comb begin
        ctrl_next = ctrl_reg;
        mode_next = mode_reg;
        aExt_next = aExt_reg;
        aHigh_next = aHigh_reg;
        aLow_next = aLow_reg;
        bExt_next = bExt_reg;
        bHigh_next = bHigh_reg;
        bLow_next = bLow_reg;
        if (regWrite) begin
            case (regAddr)
                bcq_pkg::OFF_CTRL: begin
                    ctrl_next = regWrData;
                end
                bcq_pkg::OFF_MODE: begin
                    mode_next = {regWrData[bcq_pkg::MODE_AB_BKPT_EN],
                        regWrData[bcq_pkg::MODE_FULL], 6'h00};
                end
                bcq_pkg::OFF_A_EXT: begin
                    aExt_next = regWrData[5:0];
                end
                bcq_pkg::OFF_A_HIGH: begin
                    aHigh_next = regWrData;
                end
                bcq_pkg::OFF_A_LOW: begin
                    aLow_next = regWrData;
                end
                bcq_pkg::OFF_B_EXT: begin
                    bExt_next = regWrData[5:0];
                end
                bcq_pkg::OFF_B_HIGH: begin
                    bHigh_next = regWrData;
                end
                bcq_pkg::OFF_B_LOW: begin
                    bLow_next = regWrData;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= bcq_pkg::CTRL_RESET;
            mode_reg <= bcq_pkg::MODE_RESET;
            aExt_reg <= bcq_pkg::EXT_RESET;
            aHigh_reg <= bcq_pkg::BYTE_RESET;
            aLow_reg <= bcq_pkg::BYTE_RESET;
            bExt_reg <= bcq_pkg::EXT_RESET;
            bHigh_reg <= bcq_pkg::BYTE_RESET;
            bLow_reg <= bcq_pkg::BYTE_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            aExt_reg <= aExt_next;
            aHigh_reg <= aHigh_next;
            aLow_reg <= aLow_next;
            bExt_reg <= bExt_next;
            bHigh_reg <= bHigh_next;
            bLow_reg <= bLow_next;
        end
    end

    // ************************************************************
    // Mode decode and effective masks
    // ************************************************************
    logic [1:0] maskA;
    logic [1:0] maskB;
    logic dirBEn;
    logic rawA;
    logic rawB;

    always_comb begin
        bkptMode = mode_reg[bcq_pkg::MODE_AB_BKPT_EN];
        fullMode = mode_reg[bcq_pkg::MODE_FULL];
        // First mask only has meaning in breakpoint mode
        if (bkptMode) begin
            maskA = {ctrl_reg[bcq_pkg::CTRL_AMASK_HI],
                ctrl_reg[bcq_pkg::CTRL_AMASK_LO]};
        end else begin
            maskA = bcq_pkg::MASK_NONE;
        end
        if (bkptMode || fullMode) begin
            maskB = {ctrl_reg[bcq_pkg::CTRL_BMASK_HI],
                ctrl_reg[bcq_pkg::CTRL_BMASK_LO]};
        end else begin
            maskB = bcq_pkg::MASK_NONE;
        end
        dirBEn = ctrl_reg[bcq_pkg::CTRL_B_DIR_EN] && !fullMode;
    end

    // ************************************************************
    // Comparators
    // ************************************************************
    // Paging compare is only done for breakpoint mode; capture-mode
    // page selection lives outside this block.
    bcq_comparator cmpA (
        .refExt(aExt_reg),
        .refHigh(aHigh_reg),
        .refLow(aLow_reg),
        .maskPair(maskA),
        .dataMode(1'b0),
        .pageSel(pageAccess && bkptMode),
        .cpuAddr(cpuAddr),
        .pageIndex(programPageIndex),
        .cpuData(cpuData),
        .dirEnable(ctrl_reg[bcq_pkg::CTRL_A_DIR_EN]),
        .dirValue(ctrl_reg[bcq_pkg::CTRL_A_DIR_VAL]),
        .cpuRead(cpuRead),
        .match(rawA)
    );

    bcq_comparator cmpB (
        .refExt(bExt_reg),
        .refHigh(bHigh_reg),
        .refLow(bLow_reg),
        .maskPair(maskB),
        .dataMode(fullMode),
        .pageSel(pageAccess && bkptMode && !fullMode),
        .cpuAddr(cpuAddr),
        .pageIndex(programPageIndex),
        .cpuData(cpuData),
        .dirEnable(dirBEn),
        .dirValue(ctrl_reg[bcq_pkg::CTRL_B_DIR_VAL]),
        .cpuRead(cpuRead),
        .match(rawB)
    );

    // ************************************************************
    // Match outputs, status and read data
    // ************************************************************
    logic matchA_next;
    logic matchB_next;
    logic stickyClrHit;

    always_comb begin
        // Full mode: A fires on address and data together, B stays quiet
        matchA_next = busValid && rawA && (!fullMode || rawB);
        matchB_next = busValid && rawB && !fullMode;
        stickyClrHit = regWrite && (regAddr == bcq_pkg::OFF_STATUS);
        sticky_next = sticky_reg;
        if (stickyClrHit) begin
            sticky_next = sticky_reg & ~regWrData[1:0];
        end
        // A new hit wins over a clear in the same cycle
        sticky_next = sticky_next | {matchB_next, matchA_next};
        rdData_next = 8'h00;
        if (regRead) begin
            case (regAddr)
                bcq_pkg::OFF_CTRL: rdData_next = ctrl_reg;
                bcq_pkg::OFF_MODE: rdData_next = mode_reg;
                bcq_pkg::OFF_A_EXT: rdData_next = {2'h0, aExt_reg};
                bcq_pkg::OFF_A_HIGH: rdData_next = aHigh_reg;
                bcq_pkg::OFF_A_LOW: rdData_next = aLow_reg;
                bcq_pkg::OFF_B_EXT: rdData_next = {2'h0, bExt_reg};
                bcq_pkg::OFF_B_HIGH: rdData_next = bHigh_reg;
                bcq_pkg::OFF_B_LOW: rdData_next = bLow_reg;
                bcq_pkg::OFF_STATUS: rdData_next = {4'h0, matchB, matchA, sticky_reg};
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            matchA <= 1'b0;
            matchB <= 1'b0;
            sticky_reg <= 2'h0;
            rdData_reg <= 8'h00;
        end else begin
            matchA <= matchA_next;
            matchB <= matchB_next;
            sticky_reg <= sticky_next;
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence ctrlWriteSeq;
        regWrite && regAddr == bcq_pkg::OFF_CTRL;
    endsequence

    sequence ctrlReadSeq;
        regRead && regAddr == bcq_pkg::OFF_CTRL;
    endsequence

    chk_ctrl_write_lands: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctrlWriteSeq |=> ctrl_reg == $past(regWrData))
        else $error("control register did not take write data");

    chk_ctrl_read_back: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctrlWriteSeq ##1 ctrlReadSeq |=> regRdData == $past(regWrData, 2))
        else $error("control register read back differs");

    chk_capture_mask_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !bkptMode |-> maskA == bcq_pkg::MASK_NONE)
        else $error("first mask active in capture mode");

    chk_capture_mask_b: assert property (
        @(posedge sys_clk) disable iff (rst)
        !bkptMode && !fullMode |-> maskB == bcq_pkg::MASK_NONE)
        else $error("second mask active in capture dual mode");

    chk_dir_a_qual: assert property (
        @(posedge sys_clk) disable iff (rst)
        busValid && ctrl_reg[bcq_pkg::CTRL_A_DIR_EN]
        && (ctrl_reg[bcq_pkg::CTRL_A_DIR_VAL] != cpuRead) |=> !matchA)
        else $error("comparator A matched wrong direction");

    chk_dir_b_qual: assert property (
        @(posedge sys_clk) disable iff (rst)
        busValid && !fullMode && ctrl_reg[bcq_pkg::CTRL_B_DIR_EN]
        && (ctrl_reg[bcq_pkg::CTRL_B_DIR_VAL] != cpuRead) |=> !matchB)
        else $error("comparator B matched wrong direction");

    chk_full_b_quiet: assert property (
        @(posedge sys_clk) disable iff (rst)
        fullMode && busValid |=> !matchB)
        else $error("comparator B fired in full mode");

    chk_page_window: assert property (
        @(posedge sys_clk) disable iff (rst)
        busValid && maskA == bcq_pkg::MASK_PAGE_ONLY && !pageAccess |=> !matchA)
        else $error("page window matched unpaged access");

    chk_match_cause: assert property (
        @(posedge sys_clk) disable iff (rst)
        matchA || matchB |-> $past(busValid))
        else $error("match without a bus cycle");

    chk_full_needs_data: assert property (
        @(posedge sys_clk) disable iff (rst)
        fullMode && busValid && !rawB |=> !matchA)
        else $error("full mode match without data match");

endmodule : bcq_qualifier

`default_nettype wire

// ==== test/bcq_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bcq_cpu_model (
    input wire logic sys_clk,              // Bus clock
    output logic busValid,                 // Bus cycle valid
    output logic [15:0] cpuAddr,           // CPU address
    output logic [15:0] cpuData,           // CPU data
    output logic cpuRead,                  // 1 read, 0 write
    output logic pageAccess,               // Program page window
    output logic [5:0] programPageIndex    // Program page index
);
    initial begin
        busValid = 1'b0;
        cpuAddr = 16'h0000;
        cpuData = 16'h0000;
        cpuRead = 1'b0;
        pageAccess = 1'b0;
        programPageIndex = 6'h00;
    end

    // ************************************************************
    // One bus cycle, then an optional idle gap
    // ************************************************************
    // Idle lines except pageAccess show inverted values so stale data never looks valid
    task automatic busCycle(input logic [15:0] a, input logic [15:0] d, input logic r,
                            input logic p, input logic [5:0] i, input int gap);
        busValid <= 1'b1;
        cpuAddr <= a;
        cpuData <= d;
        cpuRead <= r;
        pageAccess <= p;
        programPageIndex <= i;
        @(posedge sys_clk);
        if (gap > 0) begin
            busValid <= 1'b0;
            cpuAddr <= ~a;
            cpuData <= ~d;
            cpuRead <= ~r;
            programPageIndex <= ~i;
            repeat (gap) @(posedge sys_clk);
        end
    endtask : busCycle

    task automatic busIdle();
        busValid <= 1'b0;
        @(posedge sys_clk);
    endtask : busIdle
endmodule : bcq_cpu_model
`default_nettype wire

// ==== test/tb_breakpoint_compare_qualifier.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_breakpoint_compare_qualifier;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic busValid, cpuRead, pageAccess, matchA, matchB;
    logic [15:0] cpuAddr, cpuData;
    logic [5:0] programPageIndex;
    int num_errors = 0;
    int cmp_count = 0;
    logic [7:0] rdQ[$];
    logic [1:0] mQ[$];
    logic [7:0] sh[16] = '{default: 8'h00};
    logic rdSeen = 1'b0;
    logic bvSeen = 1'b0;
    logic [7:0] expRd;
    logic [1:0] expM;

    always #4 sys_clk = ~sys_clk;

    bcq_qualifier bcq_qualifier_inst (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .busValid(busValid), .cpuAddr(cpuAddr), .cpuData(cpuData), .cpuRead(cpuRead),
        .pageAccess(pageAccess), .programPageIndex(programPageIndex), .matchA(matchA),
        .matchB(matchB));
    bcq_cpu_model bcq_cpu_model_inst (.sys_clk(sys_clk), .busValid(busValid),
        .cpuAddr(cpuAddr), .cpuData(cpuData), .cpuRead(cpuRead), .pageAccess(pageAccess),
        .programPageIndex(programPageIndex));

    // ************************************************************
    // Reporting
    // ************************************************************
    task automatic bad(input string m);
        num_errors++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    task automatic finish_test();
        $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ************************************************************
    // Register bus and reference compare
    // ************************************************************
    function automatic logic [7:0] wm(input logic [3:0] a);
        case (a)
            4'h0, 4'h3, 4'h4, 4'h6, 4'h7: wm = 8'hFF;
            4'h1: wm = 8'hC0;
            4'h2, 4'h5: wm = 8'h3F;
            default: wm = 8'h00;
        endcase
    endfunction : wm

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regWrite <= 1'b1;
        regRead <= 1'b0;
        regAddr <= a;
        regWrData <= d;
        sh[a] = d & wm(a);
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        regRead <= 1'b1;
        regWrite <= 1'b0;
        regAddr <= a;
        rdQ.push_back(sh[a]);
        @(posedge sys_clk);
    endtask : rd

    task automatic regIdle();
        regWrite <= 1'b0;
        regRead <= 1'b0;
        @(posedge sys_clk);
    endtask : regIdle

    function automatic logic acmp(input logic [1:0] m, input logic [7:0] x, input logic [7:0] h,
                                  input logic [7:0] l, input logic [15:0] a, input logic pg,
                                  input logic [5:0] i);
        logic hOk;
        if (m == 2'b11) return pg && x[5:0] == i;
        hOk = pg ? h[5:0] == a[13:8] : h == a[15:8];
        return (!pg || x[5:0] == i) && hOk && (m == 2'b01 || l == a[7:0]);
    endfunction : acmp

    function automatic logic [1:0] refm(input logic [15:0] a, input logic [15:0] d,
                                        input logic r, input logic p, input logic [5:0] i);
        logic breakpoint_operating_mode, full, pg, aHit;
        logic [1:0] am, bm;
        breakpoint_operating_mode = sh[1][7];
        full = sh[1][6];
        am = breakpoint_operating_mode ? sh[0][7:6] : 2'b00;
        bm = (breakpoint_operating_mode || full) ? sh[0][5:4] : 2'b00;
        pg = p && breakpoint_operating_mode;
        aHit = acmp(am, sh[2], sh[3], sh[4], a, pg, i) && (!sh[0][3] || sh[0][2] == r);
        if (full) begin
            return {aHit && (bm[1] || sh[6] == d[15:8]) && (bm[0] || sh[7] == d[7:0]), 1'b0};
        end
        return {aHit, acmp(bm, sh[5], sh[6], sh[7], a, pg, i) && (!sh[0][1] || sh[0][0] == r)};
    endfunction : refm

    // ************************************************************
    // Output watcher
    // ************************************************************
    always @(posedge sys_clk) begin
        rdSeen <= regRead;
        bvSeen <= busValid;
    end

    always @(negedge sys_clk) begin
        if (!rst) begin
            expRd = rdSeen ? rdQ.pop_front() : 8'h00;
            expM = bvSeen ? mQ.pop_front() : 2'b00;
            cmp_count += 2;
            if (regRdData !== expRd) bad("read data");
            if ({matchA, matchB} !== expM) bad("match outputs");
        end
    end

    initial begin
        #200000;
        bad("timeout");
        finish_test();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [15:0] a, d;
        logic [5:0] i;
        logic p, s, r;
        logic [1:0] m;
        void'($urandom(52723));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 16; k++) rd(k[3:0]);
        for (int k = 0; k < 16; k++) if (k != 8) wr(k[3:0], 8'($urandom()));
        for (int k = 0; k < 16; k++) rd(k[3:0]);
        regIdle();
        $display("test registers done");
        // Capture mode and direction bits both exercised untagged
        for (int n = 0; n < 300; n++) begin
            for (int k = 0; k < 8; k++) wr(k[3:0], 8'($urandom()));
            wr(4'h0, sh[0]);
            rd(4'h0);
            regIdle();
            repeat (6) begin
                s = 1'($urandom());
                p = 1'($urandom());
                a = s ? {sh[6], sh[7]} : {sh[3], sh[4]};
                i = s ? sh[5][5:0] : sh[2][5:0];
                if (p) a[15:14] = 2'($urandom());
                if ($urandom() % 4 == 0) a ^= 16'h0001 << ($urandom() % 16);
                if ($urandom() % 4 == 0) i = 6'($urandom());
                d = ($urandom() % 2 == 0) ? {sh[6], sh[7]} : 16'($urandom());
                if ($urandom() % 3 == 0) d ^= 16'h0001 << ($urandom() % 16);
                // One direction draw feeds both the model and the reference
                r = 1'($urandom());
                m = refm(a, d, r, p, i);
                mQ.push_back(m);
                sh[8][1:0] = sh[8][1:0] | {m[0], m[1]};
                bcq_cpu_model_inst.busCycle(a, d, r, p, i, $urandom() % 3);
            end
            bcq_cpu_model_inst.busIdle();
            // Sticky hits collected over the burst, then cleared by ones
            rd(4'h8);
            wr(4'h8, 8'h03);
            regIdle();
        end
        repeat (3) @(posedge sys_clk);
        $display("test match done");
        finish_test();
    end

endmodule : tb_breakpoint_compare_qualifier
`default_nettype wire
